// >>> hdl/irq_enable_bank.sv
// Interrupt enable bank with flags, priorities and an Avalon-MM slave
// Operation
// - Enable bit 1 passes its source request, 0 blocks it.
// - Unimplemented bits ignore writes and read as zero.
// - Implemented enable bits are read/write and reset to zero.
// - Register 1: bit3 pin change, bit1 I2C A master, bit0 I2C A slave.
// - Register 2 high byte: timer6, DMA4, gap, compare 8..5, capture 6.
// - Register 2 low byte: capture 5..3, DMA3, CAN A, SPI B sources.
// - Register 3 high byte: DMA5, codec event and error, CAN B event.
// - Register 3 low byte: CAN B rx, pins 4/3, timers 9/8, I2C B, timer7.
// - Register 4: CAN tx requests, DMA7/6, UART errors; rest unimplemented.
// - Each enable pairs with the flag at the same position.
// - Each source has a three-bit priority; zero disables it.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module irq_enable_bank
  import irq_bank_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic [63:0] IRQ_SRC,
  output logic [63:0] IRQ_REQ,
  output logic IRQ,
  output logic [2:0] IRQ_LEVEL
);
  bank_s q, d;
  avm_req_s av;
  logic [63:0] prio_nz;
  logic [2:0] level_d;

  // Byte lanes of the 16-bit register data
  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [63:0] nonzero(input logic [63:0][2:0] p);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < SRC_N; i++) begin
      r[i] = (p[i] != PRIO_OFF);
    end
    return r;
  endfunction

  // True while no unimplemented source holds a nonzero priority
  function automatic logic prio_clean(input logic [63:0][2:0] p);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < SRC_N; i++) begin
      if (!IMPL_ALL[i] && p[i] != PRIO_OFF) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [15:0] read_word(input bank_s s,
                                            input logic [7:0] a);
    logic [15:0] r;
    logic [5:0] base;
    r = 16'h0000;
    base = {a[5:2], 2'b00};
    if (a[7:4] == EN_PAGE) begin
      r = s.en[a[3:2]];
    end else if (a[7:4] == FLAG_PAGE) begin
      r = s.flag[a[3:2]];
    end else if (a[7:6] == PRIO_PAGE) begin
      for (int i = 0; i < 4; i++) begin
        r[4*i +: 3] = s.prio[base + 6'(i)];
      end
    end
    return r;
  endfunction

  assign av = '{read: READ, write: WRITE, address: ADDRESS,
                writedata: WRITEDATA, byteenable: BYTEENABLE};

  always_comb begin
    logic [15:0] lanes;
    logic [15:0] wd;
    logic [63:0] clr;
    logic [5:0] base;
    lanes = lane_mask(av.byteenable);
    wd = av.writedata[15:0];
    clr = 64'h0;
    base = {av.address[5:2], 2'b00};
    d = q;
    case (q.bus)
      BUS_IDLE: begin
        if (av.read || av.write) begin
          d.bus = BUS_ACK;
          d.waitreq = 1'b0;
          d.rdata = {16'h0000, read_word(q, av.address)};
        end
      end
      BUS_ACK: begin
        d.bus = BUS_IDLE;
        d.waitreq = 1'b1;
        if (av.write) begin
          if (av.address[7:4] == EN_PAGE) begin
            // Only implemented positions take the written value
            d.en[av.address[3:2]] = (q.en[av.address[3:2]] & ~lanes)
              | (wd & lanes);
          end else if (av.address[7:4] == FLAG_PAGE) begin
            clr[16*av.address[3:2] +: 16] = wd & lanes;
          end else if (av.address[7:6] == PRIO_PAGE) begin
            for (int i = 0; i < 4; i++) begin
              if (lanes[4*i] && IMPL_ALL[base + 6'(i)]) begin
                d.prio[base + 6'(i)] = wd[4*i +: 3];
              end
            end
          end
        end
      end
      default: begin
        d.bus = BUS_IDLE;
        d.waitreq = 1'b1;
      end
    endcase
    d.en = d.en & IMPL_ALL;
    // Event sets the flag whatever the enable; set wins over clear
    d.flag = (q.flag & ~clr | IRQ_SRC) & IMPL_ALL;
    // Gating uses next-state values so an enable write acts next cycle
    d.req = d.flag & d.en & nonzero(d.prio);
    d.irq = |d.req;
    d.level = level_d;
  end

  prio_resolve #(
    .N(SRC_N)
  ) u_resolve (
    .pend(d.req),
    .prio(d.prio),
    .level(level_d)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q.bus <= BUS_IDLE;
      q.waitreq <= 1'b1;
      q.rdata <= RDATA_RST;
      q.en <= {4{EN_RST}};
      q.flag <= {4{FLAG_RST}};
      for (int i = 0; i < SRC_N; i++) begin
        q.prio[i] <= IMPL_ALL[i] ? PRIO_RST : PRIO_OFF;
      end
      q.req <= 64'h0;
      q.irq <= 1'b0;
      q.level <= PRIO_OFF;
    end else begin
      q <= d;
    end
  end

  assign READDATA = q.rdata;
  assign WAITREQUEST = q.waitreq;
  assign IRQ_REQ = q.req;
  assign IRQ = q.irq;
  assign IRQ_LEVEL = q.level;
  assign prio_nz = nonzero(q.prio);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  gate_block_a: assert property (
    (IRQ_REQ & ~q.en) == 64'h0)
    else $error("gated request without its enable");

  gate_pass_a: assert property (
    (q.flag & q.en & prio_nz) == IRQ_REQ)
    else $error("enabled pending source not passed on");

  unimpl_read_a: assert property (
    !WAITREQUEST && READ && ADDRESS[7:4] == EN_PAGE
    |-> (READDATA[15:0] & ~IMPL_ALL[16*ADDRESS[3:2] +: 16]) == 16'h0000)
    else $error("unimplemented enable bit read as one");

  unimpl_state_a: assert property (
    ((q.en | q.flag) & ~IMPL_ALL) == 64'h0)
    else $error("unimplemented bit holds a one");

  en_write_a: assert property (
    q.bus == BUS_ACK && WRITE && ADDRESS == EN_BASE && BYTEENABLE == 4'hF
    |=> q.en[0] == ($past(WRITEDATA[15:0]) & IMPL_EN1))
    else $error("enable register 1 write not taken");

  en_stable_a: assert property (
    !(q.bus == BUS_ACK && WRITE) |=> $stable(q.en))
    else $error("enable changed without a bus write");

  flag_set_a: assert property (
    1'b1 |=> (($past(IRQ_SRC) & IMPL_ALL) & ~q.flag) == 64'h0)
    else $error("event did not set its flag");

  prio_off_a: assert property (
    (IRQ_REQ & ~prio_nz) == 64'h0)
    else $error("request passed at priority zero");

  irq_level_a: assert property (
    IRQ == (IRQ_LEVEL != PRIO_OFF))
    else $error("level disagrees with interrupt output");

  bus_ack_a: assert property (
    q.bus == BUS_IDLE && (READ || WRITE)
    |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus answer not one cycle long");

  en_write_c: cover property (
    q.bus == BUS_ACK && WRITE && ADDRESS[7:4] == EN_PAGE);
  irq_rise_c: cover property ($rose(IRQ));
  flag_read_c: cover property (
    !WAITREQUEST && READ && ADDRESS[7:4] == FLAG_PAGE
    && READDATA != 32'h0);
  prio_top_c: cover property (IRQ_LEVEL == 3'h7);
  clear_race_c: cover property (
    q.bus == BUS_ACK && WRITE && ADDRESS[7:4] == FLAG_PAGE && IRQ_SRC != 0);

  // Register bus answer shape
  wait_idle_a: assert property (
    q.bus == BUS_IDLE |-> WAITREQUEST)
    else $error("stall missing while the slave is idle");

  ack_once_a: assert property (
    !WAITREQUEST |=> WAITREQUEST)
    else $error("answer stood longer than one cycle");

  rdata_stable_a: assert property (
    !(q.bus == BUS_IDLE && (READ || WRITE)) |=> $stable(READDATA))
    else $error("read data moved without a request");

  // Read-back, byte lanes and unimplemented positions
  rdata_upper_a: assert property (
    READDATA[31:16] == 16'h0000)
    else $error("upper read data half not zero");

  unmapped_read_a: assert property (
    !WAITREQUEST && READ && ADDRESS[7:6] != PRIO_PAGE
    && ADDRESS[7:5] != 3'b000 |-> READDATA == 32'h0000_0000)
    else $error("unmapped address read as nonzero");

  en_read_a: assert property (
    !WAITREQUEST && READ && ADDRESS[7:4] == EN_PAGE
    |-> READDATA[15:0] == q.en[ADDRESS[3:2]])
    else $error("enable register read back wrong");

  lane_keep_a: assert property (
    q.bus == BUS_ACK && WRITE && ADDRESS == 8'h04 && BYTEENABLE == 4'h1
    |=> q.en[1][15:8] == $past(q.en[1][15:8]))
    else $error("disabled byte lane changed an enable");

  prio_unimpl_a: assert property (
    prio_clean(q.prio))
    else $error("unimplemented source holds a priority");

  // Flags and gating
  flag_sticky_a: assert property (
    !(q.bus == BUS_ACK && WRITE) |=> ($past(q.flag) & ~q.flag) == 64'h0)
    else $error("flag fell without a clearing write");

  flag_clear_a: assert property (
    q.bus == BUS_ACK && WRITE && ADDRESS == FLAG_BASE
    && BYTEENABLE == 4'hF && WRITEDATA[15:0] == 16'hFFFF
    && IRQ_SRC[15:0] == 16'h0000 |=> q.flag[0] == 16'h0000)
    else $error("flag not cleared by a written one");

  clear_set_a: assert property (
    q.bus == BUS_ACK && WRITE && ADDRESS == FLAG_BASE && IRQ_SRC[0]
    |=> q.flag[0][0])
    else $error("event lost against a flag clear");

  src_req_a: assert property (
    (IRQ_SRC & q.en & prio_nz) != 64'h0 && !(q.bus == BUS_ACK && WRITE)
    |=> IRQ)
    else $error("enabled event did not raise the interrupt");

  irq_or_a: assert property (
    IRQ == (IRQ_REQ != 64'h0))
    else $error("interrupt output disagrees with requests");

  // Priority fields
  prio_stable_a: assert property (
    !(q.bus == BUS_ACK && WRITE) |=> $stable(q.prio))
    else $error("priority changed without a bus write");

  prio_write_a: assert property (
    q.bus == BUS_ACK && WRITE && ADDRESS == PRIO_BASE && BYTEENABLE == 4'hF
    |=> q.prio[0] == $past(WRITEDATA[2:0]))
    else $error("priority write not taken");

  prio_lane_a: assert property (
    q.bus == BUS_ACK && WRITE && ADDRESS == PRIO_BASE && BYTEENABLE == 4'h2
    |=> $stable(q.prio[0]))
    else $error("disabled lane changed a priority");
endmodule

// >>> common/irq_bank_pkg.sv
// Constants, register map and state types of the interrupt enable bank
package irq_bank_pkg;
  localparam int SRC_N = 64;
  localparam int PRIO_W = 3;
  // Byte addresses on the register bus
  localparam logic [7:0] EN_BASE = 8'h00;
  localparam logic [7:0] FLAG_BASE = 8'h10;
  localparam logic [7:0] PRIO_BASE = 8'h40;
  localparam logic [3:0] EN_PAGE = 4'h0;
  localparam logic [3:0] FLAG_PAGE = 4'h1;
  localparam logic [1:0] PRIO_PAGE = 2'h1;
  // Implemented bit positions; enable register 1 is bits 15:0 of the vector
  localparam logic [15:0] IMPL_EN1 = 16'h000B;
  localparam logic [15:0] IMPL_EN2 = 16'hDFFF;
  localparam logic [15:0] IMPL_EN3 = 16'h39FF;
  localparam logic [15:0] IMPL_EN4 = 16'h00F6;
  localparam logic [63:0] IMPL_ALL = {IMPL_EN4, IMPL_EN3, IMPL_EN2, IMPL_EN1};
  // Values after reset
  localparam logic [15:0] EN_RST = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [2:0] PRIO_RST = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avm_req_s;

  typedef struct packed {
    bus_e bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [3:0][15:0] en;
    logic [3:0][15:0] flag;
    logic [63:0][2:0] prio;
    logic [63:0] req;
    logic irq;
    logic [2:0] level;
  } bank_s;
endpackage

// >>> hdl/prio_resolve.sv
// Highest priority level among pending gated requests
`timescale 1ns/1ps
module prio_resolve
  import irq_bank_pkg::*;
#(
  parameter int N = SRC_N
) (
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0][2:0] prio,
  output logic [2:0] level
);
  always_comb begin
    level = PRIO_OFF;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && (prio[i] > level)) begin
        level = prio[i];
      end
    end
  end
endmodule

// >>> tb/irq_src_model.sv
// Peripheral source model that raises one request pulse on command
`timescale 1ns/1ps
module irq_src_model (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic fire,
  input wire logic [5:0] idx,
  output logic [63:0] src
);
  // Sources are synchronous to the bank clock: one-cycle pulse, else low
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      src <= 64'h0;
    end else begin
      src <= fire ? (64'h1 << idx) : 64'h0;
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
module tb;
  import irq_bank_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic fire = 1'b0;
  logic [5:0] idx = 6'h00;
  logic [7:0] ADDRESS = 8'h00;
  logic [31:0] WRITEDATA = 32'h0;
  logic [3:0] BYTEENABLE = 4'hF;
  logic [31:0] READDATA;
  logic WAITREQUEST, IRQ;
  logic [63:0] IRQ_SRC, IRQ_REQ;
  logic [2:0] IRQ_LEVEL;
  int fail_count = 0;
  int comparisons = 0;

  irq_enable_bank i_irq_enable_bank (.CLK(CLK), .NRST(NRST),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .IRQ_SRC(IRQ_SRC), .IRQ_REQ(IRQ_REQ),
    .IRQ(IRQ), .IRQ_LEVEL(IRQ_LEVEL));
  irq_src_model i_irq_src_model (.CLK(CLK), .NRST(NRST), .fire(fire),
    .idx(idx), .src(IRQ_SRC));

  initial begin
    forever #20 CLK = ~CLK;
  end

  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Request is held until waitrequest is seen low at a rising edge
  task automatic wait_ack();
    for (int n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (WAITREQUEST === 1'b0) return;
    end
    fail_count++;
    finish_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= {16'h0, d};
    WRITE <= 1'b1;
    wait_ack();
    WRITE <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge CLK);
    ADDRESS <= a;
    READ <= 1'b1;
    wait_ack();
    READ <= 1'b0;
    check("readdata", READDATA, {16'h0, exp});
  endtask

  task automatic settle();
    @(negedge CLK);
  endtask

  initial begin
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      rd(8'(4 * r), EN_RST);
      wr(8'(4 * r), 16'hFFFF);
      rd(8'(4 * r), IMPL_ALL[16 * r +: 16]);
      wr(8'(4 * r), 16'h0000);
      rd(8'(4 * r), 16'h0000);
    end
    rd(8'h30, 16'h0000);
    // Low byte lane only: the high byte keeps its value
    BYTEENABLE <= 4'h1;
    wr(8'h04, 16'hFFFF);
    BYTEENABLE <= 4'hF;
    rd(8'h04, 16'h00FF);
    wr(8'h04, 16'h0000);
    rd(8'h04, 16'h0000);
    // Pulse external pin 3 source while its enable is clear
    @(posedge CLK);
    fire <= 1'b1;
    idx <= 6'd37;
    @(posedge CLK);
    fire <= 1'b0;
    @(posedge CLK);
    settle();
    check("irq_req", IRQ_REQ, 64'h0);
    check("irq", IRQ, 64'h0);
    rd(8'h18, 16'h0020);
    wr(8'h08, 16'h0020);
    settle();
    check("irq_req", IRQ_REQ, 64'h1 << 37);
    check("irq", IRQ, 64'h1);
    check("irq_level", IRQ_LEVEL, PRIO_RST);
    wr(8'h64, 16'h0000);
    settle();
    check("irq_req", IRQ_REQ, 64'h0);
    check("irq_level", IRQ_LEVEL, 64'h0);
    wr(8'h64, 16'h0070);
    settle();
    check("irq_level", IRQ_LEVEL, 64'h7);
    wr(8'h08, 16'h0000);
    settle();
    check("irq", IRQ, 64'h0);
    rd(8'h18, 16'h0020);
    wr(8'h18, 16'h0020);
    rd(8'h18, 16'h0000);
    finish_test();
  end
endmodule
